// File: shared/pmt_pkg.sv
// package for the period match timer: register map, fields, reset values
package pmt_pkg;
    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [2:0] PMT_OFS_COUNT = 3'h0;
    localparam logic [2:0] PMT_OFS_PERIOD = 3'h1;
    localparam logic [2:0] PMT_OFS_CONTROL = 3'h2;
    localparam logic [2:0] PMT_OFS_FLAG = 3'h3;
    localparam logic [2:0] PMT_OFS_MASK = 3'h4;
    // ----------------------------------------------------------------
    // fields and reset values
    // ----------------------------------------------------------------
    localparam int PMT_PRE_LSB = 0;
    localparam int PMT_RUN_BIT = 2;
    localparam int PMT_POST_LSB = 3;
    localparam int PMT_FLAG_BIT = 1;
    localparam logic [7:0] PMT_CTRL_WMASK = 8'h7F;
    localparam logic [7:0] PMT_PERIOD_RST = 8'hFF;
    localparam logic [7:0] PMT_COUNT_RST = 8'h00;
    localparam logic [7:0] PMT_CTRL_RST = 8'h00;
    localparam logic [3:0] PMT_PRE_DIV4_LAST = 4'h3;
    localparam logic [3:0] PMT_PRE_DIV16_LAST = 4'hF;
    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [3:0] post_sel;
        logic run;
        logic [1:0] pre_sel;
    } pmt_ctrl_s;
    typedef struct packed {
        logic [7:0] count;
        logic match;
    } pmt_tbase_s;
endpackage

// File: hdl/pmt_timer.sv
// period match timer with prescaler, postscaler and flag register
//
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/10ps
// What this block does
// - 8-bit up-counter advanced by clk after the selected prescaler
// - prescale field bits 1..0: 00 divide 1, 01 divide 4, 1x divide 16
// - postscale field bits 6..3: value n gives ratio 1:(n+1)
// - matches feed 4-bit postscaler; at ratio, set period match flag bit 1
// - count equal to period returns to zero next increment; that is the match
// - period register is read/write and resets to FFh
// - count register is read/write and resets to zero
// - count write, control write or reset clears prescaler and postscaler
// - control write leaves count unchanged
// - control bit 2 runs the timer; clear stops it
// - count and match go out as PWM time base
// - control bit 7 ignores writes and reads zero
// - match before postscaler goes to serial port for shift clock
module pmt_timer (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // register port
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // time base and interrupt
    output pmt_pkg::pmt_tbase_s pwm_tbase,
    output logic serial_shift_tick,
    output logic irq
);
    import pmt_pkg::*;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0] count_r;
    logic [7:0] period_r;
    pmt_ctrl_s ctrl_r;
    logic [3:0] pre_r;
    logic [3:0] post_r;
    logic [7:0] flag_r;
    logic [7:0] mask_r;
    logic [7:0] rdata_r;
    logic match_r;
    logic wr_count;
    logic wr_ctrl;
    logic tick;
    logic match_now;
    logic post_hit;

    // last prescaler value before an increment
    function automatic logic [3:0] pre_last(input logic [1:0] sel);
        if (sel == 2'b00) begin
            pre_last = 4'h0;
        end else if (sel == 2'b01) begin
            pre_last = PMT_PRE_DIV4_LAST;
        end else begin
            pre_last = PMT_PRE_DIV16_LAST;
        end
    endfunction

    // write decodes
    assign wr_count = reg_wr && (reg_addr == PMT_OFS_COUNT);
    assign wr_ctrl = reg_wr && (reg_addr == PMT_OFS_CONTROL);

    // increment tick and match detection
    assign tick = ctrl_r.run && (pre_r == pre_last(ctrl_r.pre_sel));
    // a count write in the same cycle wins over the wrap, so no match then
    assign match_now = tick && (count_r == period_r) && !wr_count;
    assign post_hit = match_now && (post_r == ctrl_r.post_sel);

    // ----------------------------------------------------------------
    // prescaler
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn || wr_count || wr_ctrl) begin
            pre_r <= 4'h0;
        end else if (tick) begin
            pre_r <= 4'h0;
        end else if (ctrl_r.run) begin
            pre_r <= pre_r + 4'h1;
        end
    end

    // ----------------------------------------------------------------
    // counter
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            count_r <= PMT_COUNT_RST;
        end else if (wr_count) begin
            count_r <= reg_wdata;
        end else if (match_now) begin
            count_r <= 8'h00;
        end else if (tick) begin
            count_r <= count_r + 8'h01;
        end
    end

    // one-cycle match pulse, pre-postscaler
    always_ff @(posedge clk) begin
        if (!rstn) begin
            match_r <= 1'b0;
        end else begin
            match_r <= match_now;
        end
    end

    // ----------------------------------------------------------------
    // postscaler
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn || wr_count || wr_ctrl) begin
            post_r <= 4'h0;
        end else if (post_hit) begin
            post_r <= 4'h0;
        end else if (match_now) begin
            post_r <= post_r + 4'h1;
        end
    end

    // ----------------------------------------------------------------
    // period and control
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            period_r <= PMT_PERIOD_RST;
        end else if (reg_wr && reg_addr == PMT_OFS_PERIOD) begin
            period_r <= reg_wdata;
        end
    end

    // control register; bit 7 is not stored
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl_r <= pmt_ctrl_s'(PMT_CTRL_RST[6:0]);
        end else if (wr_ctrl) begin
            ctrl_r <= pmt_ctrl_s'(reg_wdata[6:0] & PMT_CTRL_WMASK[6:0]);
        end
    end

    // ----------------------------------------------------------------
    // interrupt flag and mask
    // ----------------------------------------------------------------
    // sticky flag: set by the postscaler, cleared by writing a one
    always_ff @(posedge clk) begin
        if (!rstn) begin
            flag_r <= 8'h00;
        end else begin
            if (reg_wr && reg_addr == PMT_OFS_FLAG) begin
                flag_r <= flag_r & ~reg_wdata; // write one to clear
            end
            if (post_hit) begin
                flag_r[PMT_FLAG_BIT] <= 1'b1; // set wins
            end
        end
    end

    // interrupt mask; only the period match bit is kept
    always_ff @(posedge clk) begin
        if (!rstn) begin
            mask_r <= 8'h00;
        end else if (reg_wr && reg_addr == PMT_OFS_MASK) begin
            mask_r <= reg_wdata & 8'h02;
        end
    end

    // level interrupt while an unmasked flag is set
    assign irq = |(flag_r & mask_r);

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rdata_r <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                PMT_OFS_COUNT: rdata_r <= count_r;
                PMT_OFS_PERIOD: rdata_r <= period_r;
                PMT_OFS_CONTROL: rdata_r <= {1'b0, ctrl_r};
                PMT_OFS_FLAG: rdata_r <= flag_r;
                PMT_OFS_MASK: rdata_r <= mask_r;
                default: rdata_r <= 8'h00;
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end

    // outputs
    assign reg_rdata = rdata_r;
    assign pwm_tbase = '{count: count_r, match: match_r};
    assign serial_shift_tick = match_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_wrap;
        @(posedge clk) disable iff (!rstn)
        (tick && count_r == period_r && !wr_count) |=> (count_r == 8'h00 && match_r);
    endproperty
    a_wrap: assert property (p_wrap) else $error("count did not wrap at period");

    property p_inc;
        @(posedge clk) disable iff (!rstn)
        (tick && count_r != period_r && !wr_count) |=> count_r == $past(count_r) + 8'h01;
    endproperty
    a_inc: assert property (p_inc) else $error("count did not step");

    property p_hold;
        @(posedge clk) disable iff (!rstn)
        (!ctrl_r.run && !reg_wr) |=> ($stable(count_r) && $stable(post_r));
    endproperty
    a_hold: assert property (p_hold) else $error("stopped timer moved");

    property p_div4;
        @(posedge clk) disable iff (!rstn)
        (ctrl_r.pre_sel == 2'b01 && ctrl_r.run && tick && !reg_wr) ##1
            (ctrl_r.run && !reg_wr) [*3] |-> !tick;
    endproperty
    a_div4: assert property (p_div4) else $error("divide by 4 ticked early");

    property p_clr;
        @(posedge clk) disable iff (!rstn)
        (wr_count || wr_ctrl) |=> (pre_r == 4'h0 && post_r == 4'h0);
    endproperty
    a_clr: assert property (p_clr) else $error("scalers not cleared");

    property p_ctrl_keep;
        @(posedge clk) disable iff (!rstn)
        (wr_ctrl && !tick) |=> count_r == $past(count_r);
    endproperty
    a_ctrl_keep: assert property (p_ctrl_keep) else $error("control write moved count");

    property p_flag;
        @(posedge clk) disable iff (!rstn)
        post_hit |=> flag_r[PMT_FLAG_BIT];
    endproperty
    a_flag: assert property (p_flag) else $error("flag not set");

    property p_bit7;
        @(posedge clk) disable iff (!rstn)
        (reg_rd && reg_addr == PMT_OFS_CONTROL) |=> !reg_rdata[7];
    endproperty
    a_bit7: assert property (p_bit7) else $error("control bit 7 read one");

    property p_period_rst;
        @(posedge clk) !rstn |=> period_r == PMT_PERIOD_RST;
    endproperty
    a_period_rst: assert property (p_period_rst) else $error("period reset wrong");

    // ----------------------------------------------------------------
    // checks: prescale spacing
    // ----------------------------------------------------------------
    // cycles since the last increment or scaler clear, kept apart from pre_r
    logic [4:0] gap_r;
    always_ff @(posedge clk) begin
        if (!rstn || wr_count || wr_ctrl || tick) begin
            gap_r <= 5'h00;
        end else if (ctrl_r.run) begin
            gap_r <= gap_r + 5'h01;
        end
    end

    property p_div1;
        @(posedge clk) disable iff (!rstn)
        (ctrl_r.run && ctrl_r.pre_sel == 2'b00) |-> tick;
    endproperty
    a_div1: assert property (p_div1) else $error("divide by 1 missed a step");

    property p_div4_gap;
        @(posedge clk) disable iff (!rstn)
        (ctrl_r.run && ctrl_r.pre_sel == 2'b01 && tick) |-> gap_r == {1'b0, PMT_PRE_DIV4_LAST};
    endproperty
    a_div4_gap: assert property (p_div4_gap) else $error("divide by 4 spacing wrong");

    property p_div16_gap;
        @(posedge clk) disable iff (!rstn)
        (ctrl_r.run && ctrl_r.pre_sel[1] && tick) |-> gap_r == {1'b0, PMT_PRE_DIV16_LAST};
    endproperty
    a_div16_gap: assert property (p_div16_gap) else $error("divide by 16 ticked early");

    property p_div16_due;
        @(posedge clk) disable iff (!rstn)
        (ctrl_r.run && ctrl_r.pre_sel[1] && gap_r == {1'b0, PMT_PRE_DIV16_LAST}) |-> tick;
    endproperty
    a_div16_due: assert property (p_div16_due) else $error("divide by 16 ticked late");

    // ----------------------------------------------------------------
    // checks: postscaler and flag
    // ----------------------------------------------------------------

    property p_post_bound;
        @(posedge clk) disable iff (!rstn)
        post_r <= ctrl_r.post_sel;
    endproperty
    a_post_bound: assert property (p_post_bound) else $error("postscaler past ratio");

    property p_post_step;
        @(posedge clk) disable iff (!rstn)
        (match_now && !post_hit && !wr_ctrl) |=> post_r == $past(post_r) + 4'h1;
    endproperty
    a_post_step: assert property (p_post_step) else $error("postscaler did not step");

    property p_flag_keep;
        @(posedge clk) disable iff (!rstn)
        (flag_r[PMT_FLAG_BIT] && !(reg_wr && reg_addr == PMT_OFS_FLAG && reg_wdata[PMT_FLAG_BIT]))
            |=> flag_r[PMT_FLAG_BIT];
    endproperty
    a_flag_keep: assert property (p_flag_keep) else $error("flag dropped by itself");

    property p_flag_cause;
        @(posedge clk) disable iff (!rstn)
        (!flag_r[PMT_FLAG_BIT] && !post_hit) |=> !flag_r[PMT_FLAG_BIT];
    endproperty
    a_flag_cause: assert property (p_flag_cause) else $error("flag set without ratio");

    // ----------------------------------------------------------------
    // checks: register port and reset
    // ----------------------------------------------------------------

    property p_rd_idle;
        @(posedge clk) disable iff (!rstn)
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");

    property p_rd_count;
        @(posedge clk) disable iff (!rstn)
        (reg_rd && reg_addr == PMT_OFS_COUNT) |=> reg_rdata == $past(count_r);
    endproperty
    a_rd_count: assert property (p_rd_count) else $error("count read wrong");

    property p_rd_period;
        @(posedge clk) disable iff (!rstn)
        (reg_rd && reg_addr == PMT_OFS_PERIOD) |=> reg_rdata == $past(period_r);
    endproperty
    a_rd_period: assert property (p_rd_period) else $error("period read wrong");

    property p_wr_count;
        @(posedge clk) disable iff (!rstn)
        wr_count |=> count_r == $past(reg_wdata);
    endproperty
    a_wr_count: assert property (p_wr_count) else $error("count write lost");

    property p_wr_ctrl;
        @(posedge clk) disable iff (!rstn)
        wr_ctrl |=> {1'b0, ctrl_r} == ($past(reg_wdata) & PMT_CTRL_WMASK);
    endproperty
    a_wr_ctrl: assert property (p_wr_ctrl) else $error("control write wrong");

    property p_rst_scalers;
        @(posedge clk) !rstn |=> (count_r == PMT_COUNT_RST && pre_r == 4'h0 && post_r == 4'h0);
    endproperty
    a_rst_scalers: assert property (p_rst_scalers) else $error("reset left counts");
endmodule

// File: verification/tb_period_match_timer8.sv
// self-checking testbench for the period match timer
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin num_errors++; \
    $display("BAD %s exp %h got %h", nm, ex, got); end end
module tb_period_match_timer8;
    import pmt_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    pmt_tbase_s pwm_tbase;
    logic serial_shift_tick;
    logic irq;
    int num_errors = 0;
    int n_compared = 0;
    int n;
    logic [7:0] mx;
    // 50 ns clock
    always #25 clk = ~clk;
    pmt_timer dut_u (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pwm_tbase(pwm_tbase),
        .serial_shift_tick(serial_shift_tick), .irq(irq));
    // ------------------------------------------------------------
    // bus cycles
    // ------------------------------------------------------------
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // read one register and compare
    task automatic chk_reg(input logic [2:0] a, input logic [7:0] ex);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        `CHK("reg_rdata", ex, reg_rdata)
    endtask
    // wait for the next match pulse, then count cycles to the following one
    task automatic meas(output int cyc);
        cyc = 0;
        do begin
            @(negedge clk);
            cyc++;
        end while (serial_shift_tick !== 1'b1 && cyc < 2000);
        `CHK("tbase_match", 1'b1, pwm_tbase.match)
        cyc = 0;
        mx = 8'h00;
        do begin
            @(negedge clk);
            cyc++;
            if (pwm_tbase.count > mx) mx = pwm_tbase.count;
        end while (serial_shift_tick !== 1'b1 && cyc < 2000);
    endtask
    // count must hold for 14 cycles after a scaler clear, then step by one
    task automatic step_chk(input logic [7:0] ex);
        repeat (14) begin
            @(negedge clk);
            `CHK("count_hold", ex, pwm_tbase.count)
        end
        repeat (4) @(negedge clk);
        `CHK("count_step", ex + 8'h01, pwm_tbase.count)
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        chk_reg(PMT_OFS_COUNT, 8'h00);
        chk_reg(PMT_OFS_PERIOD, 8'hFF);
        chk_reg(PMT_OFS_CONTROL, 8'h00);
        wr(PMT_OFS_CONTROL, 8'h80);
        chk_reg(PMT_OFS_CONTROL, 8'h00);
        wr(3'h5, 8'h55);
        chk_reg(3'h5, 8'h00);
    endtask
    // every prescale code with period 4
    task automatic t_prescale();
        wr(PMT_OFS_PERIOD, 8'h04);
        chk_reg(PMT_OFS_PERIOD, 8'h04);
        for (int p = 0; p < 4; p++) begin
            wr(PMT_OFS_CONTROL, {6'h01, p[1:0]});
            meas(n);
            `CHK("match_spacing", (p == 0) ? 5 : (p == 1) ? 20 : 80, n)
            `CHK("count_max", 8'h04, mx)
        end
    endtask
    // postscale ratio, flag, mask and irq
    task automatic t_post();
        int k;
        wr(PMT_OFS_MASK, 8'h02);
        for (int i = 0; i < 3; i++) begin
            wr(PMT_OFS_CONTROL, 8'h00);
            wr(PMT_OFS_FLAG, 8'h02);
            @(negedge clk);
            `CHK("irq_clear", 1'b0, irq)
            wr(PMT_OFS_CONTROL, {1'b0, (i == 0) ? 4'h0 : (i == 1) ? 4'h5 : 4'hF, 3'b100});
            k = 0;
            for (int c = 0; c < 2000 && irq !== 1'b1; c++) begin
                @(negedge clk);
                if (serial_shift_tick === 1'b1) k++;
            end
            `CHK("post_matches", (i == 0) ? 1 : (i == 1) ? 6 : 16, k)
        end
        wr(PMT_OFS_CONTROL, 8'h00);
        wr(PMT_OFS_MASK, 8'h00);
        @(negedge clk);
        `CHK("irq_masked", 1'b0, irq)
        repeat (20) @(posedge clk);
        chk_reg(PMT_OFS_FLAG, 8'h02);
        wr(PMT_OFS_FLAG, 8'h02);
        chk_reg(PMT_OFS_FLAG, 8'h00);
    endtask
    // stopped timer holds; count and control writes clear the scalers
    task automatic t_clear();
        wr(PMT_OFS_COUNT, 8'h37);
        repeat (20) @(posedge clk);
        chk_reg(PMT_OFS_COUNT, 8'h37);
        wr(PMT_OFS_PERIOD, 8'hFF);
        wr(PMT_OFS_CONTROL, 8'h07);
        repeat (7) @(posedge clk);
        wr(PMT_OFS_COUNT, 8'h20);
        step_chk(8'h20);
        repeat (5) @(posedge clk);
        wr(PMT_OFS_CONTROL, 8'h07);
        step_chk(8'h21);
    endtask
    // reset in mid-run returns the registers to their reset values
    task automatic t_rerun();
        wr(PMT_OFS_MASK, 8'h02);
        wr(PMT_OFS_PERIOD, 8'h10);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        chk_reg(PMT_OFS_COUNT, 8'h00);
        chk_reg(PMT_OFS_PERIOD, 8'hFF);
        chk_reg(PMT_OFS_CONTROL, 8'h00);
        chk_reg(PMT_OFS_MASK, 8'h00);
        `CHK("irq_reset", 1'b0, irq)
    endtask
    // ------------------------------------------------------------
    // verdict and main sequence
    // ------------------------------------------------------------
    task automatic end_sim();
        $display("checks %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        $display("BAD watchdog exp done got hang");
        end_sim();
    end
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_prescale();
        t_post();
        t_clear();
        t_rerun();
        end_sim();
    end
endmodule
